/* File: core/parallel_adapter.sv */
// Purpose: Control registers, control lines and reset of a two-port parallel adapter
// Assumes: All pins synchronous to core_clk; bus actions take effect at the fall of enable_in
// Notes:   Data pins are three signals each; the bench resolves the wires
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Clear pin held low one microsecond clears every register of both ports.
// - After clear all data pins are inputs since direction registers are zero.
// - After clear all four control lines are falling-edge interrupt inputs.
// - After clear all control-line interrupts are masked; request outputs stay high.
// - Control bit 1 picks first-line edge, bit 0 allows its interrupt.
// - Bit 5 low: second line is input, bit 4 edge, bit 3 allow.
// - Bits 5,4 = 10: second line output, bit 3 picks handshake or pulse.
// - Control bit 2 steers data address: 0 direction, 1 io register.
// - Only bits 0-5 are writable; bits 7,6 are edge-set read-only flags.
// - Flags clear on read of that port's io register, not on io writes; a control write setting bit 5 clears bit 6.
// - Port A read handshake drops its second line at enable fall ending the read.
module parallel_adapter #(
    parameter int unsigned CLEAR_CYCLES = parallel_adapter_pkg::CLEAR_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       chip_clear_in_n,
    input  wire logic       enable_in,
    input  wire logic       chip_sel,
    input  wire logic       read_not_write,
    input  wire logic       reg_sel_zero,
    input  wire logic       reg_sel_one,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic [7:0] port_a_pins_in,
    output logic      [7:0] port_a_pins_out,
    output logic      [7:0] port_a_pins_oe,
    input  wire logic [7:0] port_b_pins_in,
    output logic      [7:0] port_b_pins_out,
    output logic      [7:0] port_b_pins_oe,
    input  wire logic       port_a_strobe_in,
    input  wire logic       port_b_strobe_in,
    input  wire logic       port_a_ctrl_line_in,
    output logic            port_a_ctrl_line_out,
    output logic            port_a_ctrl_line_oe,
    input  wire logic       port_b_ctrl_line_in,
    output logic            port_b_ctrl_line_out,
    output logic            port_b_ctrl_line_oe,
    output logic            port_a_int_req_n,
    output logic            port_b_int_req_n
);
    localparam int CW = $clog2(CLEAR_CYCLES + 1);
    localparam int NP = parallel_adapter_pkg::NUM_PORTS;

    // Bus cycle captured while enable is high, acted on at its fall
    logic       e_prev_q;
    logic       acc_cs_q;
    logic       acc_rw_q;
    logic       acc_rs0_q;
    logic       acc_rs1_q;
    logic [7:0] acc_data_q;
    logic [CW-1:0] clr_cnt_q;
    logic [CW-1:0] clr_cnt_d;
    logic       e_fall;
    logic       clr_now;
    logic [7:0] rd_word;
    logic [7:0] data_out_q;
    logic       data_oe_q;

    logic [7:0] ctl_q     [NP];
    logic [7:0] ctl_d     [NP];
    logic [7:0] dir_q     [NP];
    logic [7:0] out_q     [NP];
    logic [7:0] pins_in   [NP];
    logic [7:0] io_view   [NP];
    logic       s1_in     [NP];
    logic       c2_in     [NP];
    logic       s1_prev_q [NP];
    logic       c2_prev_q [NP];
    logic       c2_out_q  [NP];
    logic       irq_n_q   [NP];
    logic       c1_edge   [NP];
    logic       c2_edge   [NP];
    logic       wr_ctl    [NP];
    logic       wr_data   [NP];
    logic       rd_io     [NP];
    logic       wr_io     [NP];

    assign e_fall  = e_prev_q & ~enable_in;
    // Clear acts while the pin is still low once it has been low long enough
    assign clr_now = ~chip_clear_in_n && (clr_cnt_q >= CW'(CLEAR_CYCLES - 1));
    assign clr_cnt_d = chip_clear_in_n ? '0 :
                       (clr_cnt_q == CW'(CLEAR_CYCLES)) ? clr_cnt_q : clr_cnt_q + 1'b1;

    assign pins_in[parallel_adapter_pkg::PORT_A] = port_a_pins_in;
    assign pins_in[parallel_adapter_pkg::PORT_B] = port_b_pins_in;
    assign s1_in[parallel_adapter_pkg::PORT_A]   = port_a_strobe_in;
    assign s1_in[parallel_adapter_pkg::PORT_B]   = port_b_strobe_in;
    assign c2_in[parallel_adapter_pkg::PORT_A]   = port_a_ctrl_line_in;
    assign c2_in[parallel_adapter_pkg::PORT_B]   = port_b_ctrl_line_in;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            e_prev_q   <= 1'b0;
            acc_cs_q   <= 1'b0;
            acc_rw_q   <= 1'b1;
            acc_rs0_q  <= 1'b0;
            acc_rs1_q  <= 1'b0;
            acc_data_q <= 8'h00;
            clr_cnt_q  <= '0;
            data_out_q <= 8'h00;
            data_oe_q  <= 1'b0;
        end else begin
            e_prev_q  <= enable_in;
            clr_cnt_q <= clr_cnt_d;
            if (enable_in) begin
                acc_cs_q   <= chip_sel;
                acc_rw_q   <= read_not_write;
                acc_rs0_q  <= reg_sel_zero;
                acc_rs1_q  <= reg_sel_one;
                acc_data_q <= data_in;
            end
            data_oe_q  <= enable_in & chip_sel & read_not_write;
            data_out_q <= rd_word;
        end
    end

    // Read view: control, or direction / io register as bit 2 steers
    assign rd_word = (reg_sel_zero == parallel_adapter_pkg::SEL_CTRL) ? ctl_q[reg_sel_one] :
                     ctl_q[reg_sel_one][parallel_adapter_pkg::CTL_SEL_IO] ?
                     io_view[reg_sel_one] : dir_q[reg_sel_one];

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic sel;
            logic c2_out_d;
            logic flag1_d;
            logic flag2_d;
            logic trig;
            assign sel = e_fall & acc_cs_q & (acc_rs1_q == 1'(p));
            assign wr_ctl[p]  = sel & ~acc_rw_q & (acc_rs0_q == parallel_adapter_pkg::SEL_CTRL);
            assign wr_data[p] = sel & ~acc_rw_q & (acc_rs0_q == parallel_adapter_pkg::SEL_DATA);
            assign rd_io[p]   = sel & acc_rw_q & (acc_rs0_q == parallel_adapter_pkg::SEL_DATA)
                                & ctl_q[p][parallel_adapter_pkg::CTL_SEL_IO];
            assign wr_io[p]   = wr_data[p] & ctl_q[p][parallel_adapter_pkg::CTL_SEL_IO];
            // Driven bits read back the output register, inputs the pin
            assign io_view[p] = (out_q[p] & dir_q[p]) | (pins_in[p] & ~dir_q[p]);
            assign c1_edge[p] = ctl_q[p][parallel_adapter_pkg::CTL_C1_RISE] ?
                                (~s1_prev_q[p] & s1_in[p]) : (s1_prev_q[p] & ~s1_in[p]);
            assign c2_edge[p] = ctl_q[p][parallel_adapter_pkg::CTL_C2_B4] ?
                                (~c2_prev_q[p] & c2_in[p]) : (c2_prev_q[p] & ~c2_in[p]);
            // New edge wins over the clearing read in the same cycle
            assign flag1_d = c1_edge[p] | (ctl_q[p][parallel_adapter_pkg::CTL_FLAG1] & ~rd_io[p]);
            assign flag2_d = ~ctl_q[p][parallel_adapter_pkg::CTL_C2_OUT] & (c2_edge[p] |
                             (ctl_q[p][parallel_adapter_pkg::CTL_FLAG2] & ~rd_io[p]));
            assign ctl_d[p] = clr_now ? parallel_adapter_pkg::REG_RESET :
                              {flag1_d, flag2_d, wr_ctl[p] ? acc_data_q[5:0] : ctl_q[p][5:0]};
            // Port A answers reads, port B answers writes
            assign trig = (p == parallel_adapter_pkg::PORT_A) ? rd_io[p] : wr_io[p];
            always_comb begin
                c2_out_d = c2_out_q[p];
                if (!ctl_q[p][parallel_adapter_pkg::CTL_C2_OUT]) begin
                    c2_out_d = 1'b1;
                end else if (ctl_q[p][parallel_adapter_pkg::CTL_C2_B4]) begin
                    c2_out_d = ctl_q[p][parallel_adapter_pkg::CTL_C2_B3];
                end else if (trig) begin
                    c2_out_d = 1'b0;
                end else if (ctl_q[p][parallel_adapter_pkg::CTL_C2_B3]) begin
                    if (e_fall) begin
                        c2_out_d = 1'b1;
                    end
                end else if (c1_edge[p]) begin
                    c2_out_d = 1'b1;
                end
            end
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    ctl_q[p]     <= parallel_adapter_pkg::REG_RESET;
                    dir_q[p]     <= parallel_adapter_pkg::REG_RESET;
                    out_q[p]     <= parallel_adapter_pkg::REG_RESET;
                    s1_prev_q[p] <= 1'b1;
                    c2_prev_q[p] <= 1'b1;
                    c2_out_q[p]  <= 1'b1;
                    irq_n_q[p]   <= 1'b1;
                end else begin
                    s1_prev_q[p] <= s1_in[p];
                    c2_prev_q[p] <= c2_in[p];
                    ctl_q[p]     <= ctl_d[p];
                    if (clr_now) begin
                        dir_q[p]    <= parallel_adapter_pkg::REG_RESET;
                        out_q[p]    <= parallel_adapter_pkg::REG_RESET;
                        c2_out_q[p] <= 1'b1;
                    end else begin
                        c2_out_q[p] <= c2_out_d;
                        if (wr_data[p] && !ctl_q[p][parallel_adapter_pkg::CTL_SEL_IO]) begin
                            dir_q[p] <= acc_data_q;
                        end
                        if (wr_io[p]) begin
                            out_q[p] <= acc_data_q;
                        end
                    end
                    irq_n_q[p] <= ~((ctl_d[p][parallel_adapter_pkg::CTL_FLAG1]
                                     & ctl_d[p][parallel_adapter_pkg::CTL_C1_ALLOW])
                                  | (ctl_d[p][parallel_adapter_pkg::CTL_FLAG2]
                                     & ctl_d[p][parallel_adapter_pkg::CTL_C2_B3]
                                     & ~ctl_d[p][parallel_adapter_pkg::CTL_C2_OUT]));
                end
            end
        end
    endgenerate

    assign data_out             = data_out_q;
    assign data_oe              = data_oe_q;
    assign port_a_pins_out      = out_q[parallel_adapter_pkg::PORT_A];
    assign port_a_pins_oe       = dir_q[parallel_adapter_pkg::PORT_A];
    assign port_b_pins_out      = out_q[parallel_adapter_pkg::PORT_B];
    assign port_b_pins_oe       = dir_q[parallel_adapter_pkg::PORT_B];
    assign port_a_ctrl_line_out = c2_out_q[parallel_adapter_pkg::PORT_A];
    assign port_a_ctrl_line_oe  = ctl_q[parallel_adapter_pkg::PORT_A][5];
    assign port_b_ctrl_line_out = c2_out_q[parallel_adapter_pkg::PORT_B];
    assign port_b_ctrl_line_oe  = ctl_q[parallel_adapter_pkg::PORT_B][5];
    assign port_a_int_req_n     = irq_n_q[parallel_adapter_pkg::PORT_A];
    assign port_b_int_req_n     = irq_n_q[parallel_adapter_pkg::PORT_B];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_hold_low;
        !chip_clear_in_n [*8] ##1 !chip_clear_in_n [*2];
    endsequence
    property p_clear;
        s_hold_low |=> ctl_q[0] == 8'h00 && ctl_q[1] == 8'h00 && out_q[0] == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("registers not cleared");
    property p_dir_input;
        clr_now |=> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00;
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("pins not inputs");
    property p_fall_flag;
        !clr_now && !ctl_q[0][1] && s1_prev_q[0] && !port_a_strobe_in |=> ctl_q[0][7];
    endproperty
    a_fall_flag: assert property (p_fall_flag) else $error("edge flag missed");
    property p_masked;
        !clr_now && !ctl_q[1][0] && !ctl_q[1][3] && !wr_ctl[1] |=> port_b_int_req_n;
    endproperty
    a_masked: assert property (p_masked) else $error("masked request drove low");
    property p_follow;
        !clr_now && ctl_q[0][5:4] == 2'b11 |=> port_a_ctrl_line_out == $past(ctl_q[0][3]);
    endproperty
    a_follow: assert property (p_follow) else $error("output not following");
    property p_wr_mask;
        !clr_now && wr_ctl[0] && !c1_edge[0] && !c2_edge[0] && !ctl_q[0][5]
            |=> ctl_q[0] == {$past(ctl_q[0][7:6]), $past(acc_data_q[5:0])};
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("control write wrong");
    property p_flag_clear;
        !clr_now && rd_io[1] && !c1_edge[1] |=> !ctl_q[1][7];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    sequence s_hs_read;
        ctl_q[0][5:3] == 3'b100 && rd_io[0] && !clr_now;
    endsequence
    property p_hs_read;
        s_hs_read |=> !port_a_ctrl_line_out;
    endproperty
    a_hs_read: assert property (p_hs_read) else $error("handshake not dropped");
    property p_dir_write;
        !clr_now && wr_data[0] && !ctl_q[0][2] |=> dir_q[0] == $past(acc_data_q);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");
endmodule
`default_nettype wire

/* File: core/parallel_adapter_pkg.sv */
// Purpose: Shared constants of the two-port parallel adapter control logic
// Assumes: Single 10 MHz core clock
// Notes:   Control bit positions are shared by both ports
package parallel_adapter_pkg;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CLEAR_MIN_NS    = 1000;
    // Least hold time of the clear pin, rounded up to whole cycles
    localparam int CLEAR_CYCLES    = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_PORTS       = 2;
    localparam int PORT_A          = 0;
    localparam int PORT_B          = 1;
    // Control register fields
    localparam int CTL_C1_ALLOW    = 0;
    localparam int CTL_C1_RISE     = 1;
    localparam int CTL_SEL_IO      = 2;
    localparam int CTL_C2_B3       = 3;
    localparam int CTL_C2_B4       = 4;
    localparam int CTL_C2_OUT      = 5;
    localparam int CTL_FLAG2       = 6;
    localparam int CTL_FLAG1       = 7;
    localparam int CTL_WR_BITS     = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Register select: zero line picks data (0) or control (1), one line picks the port
    localparam logic SEL_DATA      = 1'b0;
    localparam logic SEL_CTRL      = 1'b1;
endpackage

/* File: verif/peripheral_model.sv */
// Purpose: Peripheral side of both ports, resolving data pins and second control lines
// Assumes: Undriven data pins see a fixed level pattern held by the peripheral
// Notes:   Patterns differ per port so a swapped port shows on read-back
`timescale 1ns/1ps
`default_nettype none
module peripheral_model #(
    parameter logic [7:0] PAT_A = 8'h3C,
    parameter logic [7:0] PAT_B = 8'hC3
) (
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe,
    input  wire logic       ca_out,
    input  wire logic       ca_oe,
    input  wire logic       cb_out,
    input  wire logic       cb_oe,
    input  wire logic       cmd_a,
    input  wire logic       cmd_b,
    output logic      [7:0] a_in,
    output logic      [7:0] b_in,
    output logic            ca_in,
    output logic            cb_in
);
    // Adapter level where it drives, the peripheral's own level elsewhere
    assign a_in  = (a_out & a_oe) | (PAT_A & ~a_oe);
    assign b_in  = (b_out & b_oe) | (PAT_B & ~b_oe);
    assign ca_in = ca_oe ? ca_out : cmd_a;
    assign cb_in = cb_oe ? cb_out : cmd_b;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the parallel adapter control logic
// Assumes: 10 MHz core clock; clear pin keeps its default ten-cycle hold
// Notes:   Each bus action is given two edges after enable falls to land
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic R = 1'b1, W = 1'b0, C = 1'b1, D = 1'b0, PA = 1'b0, PB = 1'b1;
    logic       core_clk, rst, clr_n, en, cs, rnw, rs0, rs1, stb_a, stb_b, cmd_a, cmd_b;
    logic       doe, ca_in, ca_out, ca_oe, cb_in, cb_out, cb_oe, irq_a_n, irq_b_n;
    logic [7:0] din, dout, rd, a_in, a_out, a_oe, b_in, b_out, b_oe;
    int         n_mismatch = 0;
    int         comparisons = 0;

    parallel_adapter i_dut (
        .core_clk(core_clk), .rst(rst), .chip_clear_in_n(clr_n), .enable_in(en),
        .chip_sel(cs), .read_not_write(rnw), .reg_sel_zero(rs0), .reg_sel_one(rs1),
        .data_in(din), .data_out(dout), .data_oe(doe),
        .port_a_pins_in(a_in), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe),
        .port_b_pins_in(b_in), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe),
        .port_a_strobe_in(stb_a), .port_b_strobe_in(stb_b),
        .port_a_ctrl_line_in(ca_in), .port_a_ctrl_line_out(ca_out), .port_a_ctrl_line_oe(ca_oe),
        .port_b_ctrl_line_in(cb_in), .port_b_ctrl_line_out(cb_out), .port_b_ctrl_line_oe(cb_oe),
        .port_a_int_req_n(irq_a_n), .port_b_int_req_n(irq_b_n));
    peripheral_model i_periph (
        .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .ca_out(ca_out),
        .ca_oe(ca_oe), .cb_out(cb_out), .cb_oe(cb_oe), .cmd_a(cmd_a), .cmd_b(cmd_b),
        .a_in(a_in), .b_in(b_in), .ca_in(ca_in), .cb_in(cb_in));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One enable pulse; read data is taken at the edge that ends the pulse
    task automatic bus(input logic r, input logic s0, input logic s1, input logic [7:0] d);
        @(posedge core_clk);
        en  <= 1'b1;
        cs  <= 1'b1;
        rnw <= r;
        {rs1, rs0} <= {s1, s0};
        din <= d;
        @(posedge core_clk);
        en <= 1'b0;
        cs <= 1'b0;
        #1 rd = dout;
        check({7'h00, doe}, {7'h00, r});
        repeat (2) @(posedge core_clk);
        // Return on a falling edge so checks see settled outputs
        @(negedge core_clk);
    endtask
    // Order: strobe A, strobe B, second line A, second line B
    task automatic lines(input logic [3:0] v);
        @(posedge core_clk);
        {stb_a, stb_b, cmd_a, cmd_b} <= v;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset;
        check(a_oe, 8'h00);
        check(b_oe, 8'h00);
        check({6'h00, ca_oe, cb_oe}, 8'h00);
        bus(R, C, PA, 8'h00);
        check(rd, 8'h00);
        bus(R, C, PB, 8'h00);
        check(rd, 8'h00);
        bus(R, D, PA, 8'h00);
        check(rd, 8'h00);
        bus(W, D, PA, 8'h0F);
        check(a_oe, 8'h0F);
        bus(R, D, PA, 8'h00);
        check(rd, 8'h0F);
        bus(W, D, PA, 8'h00);
    endtask
    task automatic t_flags;
        lines(4'h0);
        check({6'h00, irq_a_n, irq_b_n}, 8'h03);
        bus(R, C, PB, 8'h00);
        check(rd, 8'hC0);
        bus(W, C, PA, 8'hC5);
        bus(R, C, PA, 8'h00);
        check(rd, 8'hC5);
        check({7'h00, irq_a_n}, 8'h00);
        bus(W, D, PA, 8'h00);
        bus(R, C, PA, 8'h00);
        check(rd, 8'hC5);
        bus(R, D, PA, 8'h00);
        check(rd, 8'h3C);
        check({7'h00, irq_a_n}, 8'h01);
        bus(W, C, PA, 8'h07);
        lines(4'hA);
        bus(R, C, PA, 8'h00);
        check(rd, 8'h87);
        bus(R, D, PA, 8'h00);
        lines(4'h2);
        bus(R, C, PA, 8'h00);
        check(rd, 8'h07);
    endtask
    task automatic t_line2;
        bus(W, C, PB, 8'h1C);
        bus(R, D, PB, 8'h00);
        check(rd, 8'hC3);
        lines(4'h3);
        bus(R, C, PB, 8'h00);
        check(rd, 8'h5C);
        check({7'h00, irq_b_n}, 8'h00);
        bus(R, D, PB, 8'h00);
    endtask
    task automatic t_outputs;
        bus(W, C, PA, 8'h3C);
        check({6'h00, ca_oe, ca_out}, 8'h03);
        bus(W, C, PA, 8'h34);
        check({6'h00, ca_oe, ca_out}, 8'h02);
        bus(W, C, PA, 8'h24);
        lines(4'hB);
        lines(4'h3);
        check({6'h00, ca_oe, ca_out}, 8'h03);
        bus(R, D, PA, 8'h00);
        check({7'h00, ca_out}, 8'h00);
        bus(W, C, PA, 8'h2C);
        bus(R, C, PA, 8'h00);
        check({7'h00, ca_out}, 8'h01);
        bus(R, D, PA, 8'h00);
        check({7'h00, ca_out}, 8'h00);
        bus(R, C, PA, 8'h00);
        check({7'h00, ca_out}, 8'h01);
    endtask
    task automatic t_direction;
        bus(W, C, PB, 8'h04);
        bus(W, D, PB, 8'hFF);
        bus(W, C, PB, 8'h00);
        check(b_oe, 8'h00);
        bus(W, D, PB, 8'hFF);
        check(b_oe, 8'hFF);
        check(b_out, 8'hFF);
        bus(W, C, PB, 8'h27);
        bus(R, C, PB, 8'h00);
        check(rd, 8'h27);
        bus(R, D, PB, 8'h00);
        check(rd, 8'hFF);
        // Select lines unswapped: address bit 0 on zero line, bit 1 on one line
        bus(R, 1'b0, 1'b0, 8'h00);
        check(rd, 8'h3C);
        bus(R, 1'b0, 1'b1, 8'h00);
        check(rd, 8'hFF);
        bus(W, D, PB, 8'h5A);
        check({6'h00, cb_oe, cb_out}, 8'h02);
        check(b_out, 8'h5A);
        lines(4'h7);
        check({6'h00, cb_oe, cb_out}, 8'h03);
        check({7'h00, irq_b_n}, 8'h00);
    endtask
    task automatic t_clear;
        bus(W, C, PA, 8'h3F);
        @(posedge core_clk);
        clr_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        clr_n <= 1'b1;
        @(posedge core_clk);
        check(b_oe, 8'hFF);
        clr_n <= 1'b0;
        repeat (11) @(posedge core_clk);
        clr_n <= 1'b1;
        check(b_oe, 8'h00);
        check({6'h00, ca_oe, cb_oe}, 8'h00);
        check({6'h00, irq_a_n, irq_b_n}, 8'h03);
        bus(R, C, PA, 8'h00);
        check(rd, 8'h00);
    endtask

    initial begin
        {rst, clr_n, en, cs, rnw, rs0, rs1, din} = {3'b110, 4'h0, 8'h00};
        {stb_a, stb_b, cmd_a, cmd_b} = 4'hF;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_flags;
        t_line2;
        t_outputs;
        t_direction;
        t_clear;
        print_verdict;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #(100 * 4000);
        n_mismatch++;
        print_verdict;
    end
endmodule
`default_nettype wire
